// ===== core/fwsr_host.sv
// Host-side status poller for an embedded-algorithm parallel flash.
// Assumes software issues the program/erase command itself before starting a poll.
//
// Added by the designer: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module fwsr_host #(
   parameter int AW = 20
) (
   input  wire logic          SYS_CLK,        // 20 MHz clock
   input  wire logic          RST_N,          // Sync reset, active low
   input  wire logic [7:0]    S_AWADDR,       // AXI write address
   input  wire logic          S_AWVALID,      // AXI
   output logic               S_AWREADY,      // AXI
   input  wire logic [31:0]   S_WDATA,        // AXI
   input  wire logic [3:0]    S_WSTRB,        // AXI
   input  wire logic          S_WVALID,       // AXI
   output logic               S_WREADY,       // AXI
   output logic [1:0]         S_BRESP,        // AXI
   output logic               S_BVALID,       // AXI
   input  wire logic          S_BREADY,       // AXI
   input  wire logic [7:0]    S_ARADDR,       // AXI
   input  wire logic          S_ARVALID,      // AXI
   output logic               S_ARREADY,      // AXI
   output logic [31:0]        S_RDATA,        // AXI
   output logic [1:0]         S_RRESP,        // AXI
   output logic               S_RVALID,       // AXI
   input  wire logic          S_RREADY,       // AXI
   output logic               FL_CE_N,        // Flash chip select
   output logic               FL_OE_N,        // Flash output enable
   output logic [AW-1:0]      FL_A,           // Flash address
   input  wire logic [7:0]    FL_DQ_IN,       // Flash data in
   input  wire logic          OP_DONE_PIN     // Open-drain ready/busy, pulled up
);
   // Address register is AW bits wide and must fit in one bus word
   if (AW < 1 || AW > 32) begin : g_aw_check
      $error("AW out of range");
   end
   typedef enum logic [2:0] {
      FWSR_IDLE = 3'b000, FWSR_RD1 = 3'b001, FWSR_RD2 = 3'b011,
      FWSR_CHK = 3'b010, FWSR_END = 3'b110
   } fwsr_st_e;
   fwsr_st_e st_q;
   logic [2:0]    ctrl_q;
   logic [AW-1:0] addr_q;
   logic [7:0]    exp_q, prev_q, last_q;
   logic          busy_q, done_q, fail_q, win_q, tout_seen_q;
   logic          rd_start_q;
   logic          rdy1_q, rdy2_q, rdy3_q, rdy_q;
   logic          aw_q, w_q;
   logic [7:0]    awa_q;
   logic [31:0]   wd_q;
   wire           rd_busy, rd_done;
   wire [7:0]     rd_byte;
   fwsr_rdcyc #(.AW(AW)) u_rd (
      .clk(SYS_CLK), .rst_n(RST_N), .start(rd_start_q), .addr(addr_q),
      .busy(rd_busy), .done(rd_done), .rdata(rd_byte),
      .ce_n(FL_CE_N), .oe_n(FL_OE_N), .a(FL_A), .dq_in(FL_DQ_IN)
   );
   ////////////////////////////////////////////////////////////////////////
   // Ready/busy pin: three flops, change accepted when last two agree
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         rdy1_q <= 1'b1; rdy2_q <= 1'b1; rdy3_q <= 1'b1; rdy_q <= 1'b1;
      end else begin
         rdy1_q <= OP_DONE_PIN; rdy2_q <= rdy1_q; rdy3_q <= rdy2_q;
         if (rdy2_q == rdy3_q) rdy_q <= rdy3_q;  // [R9] [R10]
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave
   wire wr_go  = aw_q && w_q && !S_BVALID;
   wire wr_ctl = wr_go && (awa_q == fwsr_pkg::REG_CTRL) && wd_q[fwsr_pkg::CTRL_GO] && !busy_q;
   wire wr_ok  = (awa_q == fwsr_pkg::REG_CTRL) || (awa_q == fwsr_pkg::REG_ADDR) ||
                 (awa_q == fwsr_pkg::REG_DATA);
   wire [31:0] status_w = {27'h0, win_q, rdy_q, fail_q, done_q, busy_q};
   wire [31:0] rd_mux =
      (S_ARADDR == fwsr_pkg::REG_CTRL)   ? {29'h0, ctrl_q} :
      (S_ARADDR == fwsr_pkg::REG_ADDR)   ? 32'(addr_q) :
      (S_ARADDR == fwsr_pkg::REG_DATA)   ? {24'h0, exp_q} :
      (S_ARADDR == fwsr_pkg::REG_STATUS) ? status_w :
      (S_ARADDR == fwsr_pkg::REG_LAST)   ? {24'h0, last_q} : 32'h0;
   wire rd_hit = (S_ARADDR <= fwsr_pkg::REG_LAST) && (S_ARADDR[1:0] == 2'b00);
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         aw_q <= 1'b0; w_q <= 1'b0; awa_q <= 8'h00; wd_q <= 32'h0;
         S_AWREADY <= 1'b0; S_WREADY <= 1'b0; S_BVALID <= 1'b0; S_BRESP <= fwsr_pkg::AXI_OKAY;
         S_ARREADY <= 1'b0; S_RVALID <= 1'b0; S_RDATA <= 32'h0; S_RRESP <= fwsr_pkg::AXI_OKAY;
      end else begin
         S_AWREADY <= !aw_q && !S_AWREADY && S_AWVALID;
         S_WREADY  <= !w_q && !S_WREADY && S_WVALID;
         if (S_AWVALID && S_AWREADY) begin aw_q <= 1'b1; awa_q <= S_AWADDR; end
         if (S_WVALID && S_WREADY) begin w_q <= 1'b1; wd_q <= S_WDATA; end
         if (wr_go) begin
            aw_q <= 1'b0; w_q <= 1'b0; S_BVALID <= 1'b1;
            S_BRESP <= wr_ok ? fwsr_pkg::AXI_OKAY : fwsr_pkg::AXI_SLVERR;
         end else if (S_BREADY) S_BVALID <= 1'b0;
         S_ARREADY <= !S_ARREADY && !S_RVALID && S_ARVALID;
         if (S_ARVALID && S_ARREADY) begin
            S_RVALID <= 1'b1; S_RDATA <= rd_mux;
            S_RRESP <= rd_hit ? fwsr_pkg::AXI_OKAY : fwsr_pkg::AXI_SLVERR;
         end else if (S_RREADY) S_RVALID <= 1'b0;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // Poll engine
   // Poll done: erase wants 1, program wants true datum [R2] [R3] [R5]
   wire poll_ok   = ctrl_q[fwsr_pkg::CTRL_ERASE] ? rd_byte[fwsr_pkg::POLL_BIT]
                                                 : (rd_byte[fwsr_pkg::POLL_BIT] == exp_q[fwsr_pkg::POLL_BIT]);
   wire tog_moved = (rd_byte[fwsr_pkg::TOG1_BIT] != prev_q[fwsr_pkg::TOG1_BIT]);  // [R11] [R18]
   wire tout      = rd_byte[fwsr_pkg::TOUT_BIT];  // [R22]
   always_ff @(posedge SYS_CLK) begin
      if (!RST_N) begin
         st_q <= FWSR_IDLE; ctrl_q <= 3'h0; addr_q <= '0; exp_q <= 8'h00;
         prev_q <= 8'h00; last_q <= 8'h00; busy_q <= 1'b0; done_q <= 1'b0;
         fail_q <= 1'b0; win_q <= 1'b0; tout_seen_q <= 1'b0; rd_start_q <= 1'b0;
      end else begin
         rd_start_q <= 1'b0;
         if (wr_go && !busy_q && awa_q == fwsr_pkg::REG_ADDR) addr_q <= wd_q[AW-1:0];  // [R6] [R7]
         if (wr_go && !busy_q && awa_q == fwsr_pkg::REG_DATA) exp_q <= wd_q[7:0];
         if (wr_go && !busy_q && awa_q == fwsr_pkg::REG_CTRL) ctrl_q <= wd_q[2:0];
         if (rd_done) last_q <= rd_byte;
         unique case (st_q)
            FWSR_IDLE: if (wr_ctl) begin
               // Each start begins the check from its first read [R21]
               st_q <= FWSR_RD1; busy_q <= 1'b1; done_q <= 1'b0; fail_q <= 1'b0;
               tout_seen_q <= 1'b0; rd_start_q <= 1'b1;
            end
            FWSR_RD1: if (rd_done) begin
               prev_q <= rd_byte; win_q <= rd_byte[fwsr_pkg::EWIN_BIT];  // [R23]
               if (!ctrl_q[fwsr_pkg::CTRL_TOG] && poll_ok) begin
                  st_q <= FWSR_CHK; rd_start_q <= 1'b1;  // Confirm on a later read [R8]
               end else if (!ctrl_q[fwsr_pkg::CTRL_TOG] && tout) begin
                  if (tout_seen_q) begin st_q <= FWSR_END; fail_q <= 1'b1; end
                  else begin tout_seen_q <= 1'b1; rd_start_q <= 1'b1; end  // [R20]
               end else begin
                  st_q <= ctrl_q[fwsr_pkg::CTRL_TOG] ? FWSR_RD2 : FWSR_RD1;
                  rd_start_q <= 1'b1;
               end
            end
            FWSR_RD2: if (rd_done) begin
               prev_q <= rd_byte; win_q <= rd_byte[fwsr_pkg::EWIN_BIT];
               if (!tog_moved) begin
                  st_q <= FWSR_END; done_q <= 1'b1;  // [R18] [R13] [R4]
               end else if (tout && tout_seen_q) begin
                  st_q <= FWSR_END; fail_q <= 1'b1;  // [R19]
               end else begin
                  tout_seen_q <= tout; rd_start_q <= 1'b1;
               end
            end
            FWSR_CHK: if (rd_done) begin
               st_q <= FWSR_END; done_q <= poll_ok; fail_q <= !poll_ok;
            end
            default: begin
               st_q <= FWSR_IDLE; busy_q <= 1'b0;
            end
         endcase
      end
   end
   wire unused_ok = rd_busy | (|S_WSTRB);
endmodule : fwsr_host

// ===== core/fwsr_pkg.sv
// Constants shared by the flash status poller host controller.
// Assumes a 20 MHz system clock and an asynchronous parallel flash outside.
// Contract
// [R1] Device status is valid from the last write strobe's rising edge.
// [R2] Poll bit reads inverted data while programming, true data when done.
// [R3] Same poll bit behaviour for programming during erase suspend.
// [R4] Program to protected sector shows busy about 2 us, then array data.
// [R5] Poll bit reads 0 during erase, 1 when done or suspended.
// [R6] Host polls at the programmed address during a program.
// [R7] Host polls at an address inside an erasing sector during erase.
// [R8] Poll bit may change alone; host trusts data only on later reads.
// [R9] Ready/busy is open-drain, shared, valid from final write strobe.
// [R10] Ready/busy low while erasing or programming, released when readable.
// [R11] Toggle one inverts each read while an operation is active.
// [R12] Toggle one valid from final strobe; reads ended by OE or CE.
// [R13] All-protected erase toggles about 100 us, then array reads.
// [R14] Partly protected erase skips protected sectors silently.
// [R15] Toggle one stops in erase suspend.
// [R16] Toggle one toggles during suspend programming, stops when done.
// [R17] Toggle two inverts on reads inside selected erase sectors.
// [R18] Host compares two consecutive full status reads; no change means done. The host compares only toggle one (bit 6) of the two reads.
// [R19] Toggling with timeout bit high: recheck; still toggling is failure, reset. The poller only sets its fail bit and issues no reset.
// [R20] Host rechecks poll bit after timeout bit seen set.
// [R21] Host restarts toggle check from its first step after any pause.
// [R22] Timeout bit set to 1 on pulse limit excess; host must reset. The poller only sets its fail bit and issues no reset.
// [R23] Erase window bit 0 while accepting sectors, 1 once erase begins.
// [R24] Status byte replaces array data on qualifying reads.
// [R25] Toggle bits invert once per completed read cycle.
package fwsr_pkg;
   // AXI4-Lite register byte offsets
   localparam logic [7:0] REG_CTRL   = 8'h00;  // [0] go, [1] mode poll(0)/toggle(1), [2] erase
   localparam logic [7:0] REG_ADDR   = 8'h04;
   localparam logic [7:0] REG_DATA   = 8'h08;  // Expected byte for poll mode
   localparam logic [7:0] REG_STATUS = 8'h0c;
   localparam logic [7:0] REG_LAST   = 8'h10;  // Last byte read from flash
   localparam int CTRL_GO    = 0;
   localparam int CTRL_TOG   = 1;
   localparam int CTRL_ERASE = 2;
   localparam int ST_BUSY    = 0;
   localparam int ST_DONE    = 1;
   localparam int ST_FAIL    = 2;
   localparam int ST_RDY_PIN = 3;
   localparam int ST_WINDOW  = 4;
   // Status bit positions in the flash data byte
   localparam int POLL_BIT  = 7;
   localparam int TOG1_BIT  = 6;
   localparam int TOUT_BIT  = 5;
   localparam int EWIN_BIT  = 3;
   localparam int TOG2_BIT  = 2;
   // Read cycle timing: flash access 90 ns max plus margin
   localparam int CLK_NS       = 50;
   localparam int T_ACC_NS     = 120;
   localparam int T_GAP_NS     = 50;
   localparam logic [3:0] ACC_CYC = 4'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] GAP_CYC = 4'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
   localparam logic [3:0] SYNC_CYC = 4'h3;  // Depth of the data pin synchroniser
   localparam logic [1:0] AXI_OKAY   = 2'b00;
   localparam logic [1:0] AXI_SLVERR = 2'b10;
endpackage : fwsr_pkg

// ===== core/fwsr_rdcyc.sv
// Single asynchronous flash read cycle engine.
// Assumes flash data pins are synchronised here; one request at a time.
`timescale 1ns/1ps
module fwsr_rdcyc #(
   parameter int AW = 20
) (
   input  wire logic          clk,      // System clock
   input  wire logic          rst_n,    // Sync reset, active low
   input  wire logic          start,    // One-cycle request
   input  wire logic [AW-1:0] addr,     // Read address
   output logic               busy,     // Cycle in progress
   output logic               done,     // One-cycle pulse, data valid
   output logic [7:0]         rdata,    // Sampled byte
   output logic               ce_n,     // Chip select pin
   output logic               oe_n,     // Output enable pin
   output logic [AW-1:0]      a,        // Address pins
   input  wire logic [7:0]    dq_in     // Data pins in
);
   logic [7:0] s1_q, s2_q, s3_q;
   logic [3:0] cnt_q;
   typedef enum logic [1:0] {
      FWSR_PH_IDLE = 2'b00,
      FWSR_PH_ACC  = 2'b01,
      FWSR_PH_GAP  = 2'b11
   } fwsr_ph_e;
   fwsr_ph_e   ph_q;  // Idle, access, recovery gap
   // Three flops; data stable once last two agree
   wire stable = (s2_q == s3_q);
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s1_q <= 8'h00; s2_q <= 8'h00; s3_q <= 8'h00;
      end else begin
         s1_q <= dq_in; s2_q <= s1_q; s3_q <= s2_q;
      end
   end
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ph_q <= FWSR_PH_IDLE; cnt_q <= 4'h0; ce_n <= 1'b1; oe_n <= 1'b1;
         a <= '0; rdata <= 8'h00; done <= 1'b0; busy <= 1'b0;
      end else begin
         done <= 1'b0;
         unique case (ph_q)
            FWSR_PH_IDLE: if (start) begin
               ph_q <= FWSR_PH_ACC; a <= addr; ce_n <= 1'b0; oe_n <= 1'b0;
               // Access time plus synchroniser depth, so the byte sampled is from this cycle
               cnt_q <= fwsr_pkg::ACC_CYC + fwsr_pkg::SYNC_CYC; busy <= 1'b1;
            end
            FWSR_PH_ACC: if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
               else if (stable) begin
                  // Raising OE/CE ends the cycle; the device toggles here [R25] [R12]
                  rdata <= s3_q; ce_n <= 1'b1; oe_n <= 1'b1;
                  ph_q <= FWSR_PH_GAP; cnt_q <= fwsr_pkg::GAP_CYC;
               end
            default: if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
               else begin
                  ph_q <= FWSR_PH_IDLE; busy <= 1'b0; done <= 1'b1;
               end
         endcase
      end
   end
endmodule : fwsr_rdcyc

// ===== bench/fwsr_host_checker.sv
// Assertions on the poller's bus and flash read pins.
// Bound onto every fwsr_host; sees its ports only.
`timescale 1ns/1ps
module fwsr_host_checker #(
   parameter int AW = 20
) (
   input wire logic          SYS_CLK,   // Clock
   input wire logic          RST_N,     // Reset
   input wire logic          FL_CE_N,   // Chip select
   input wire logic          FL_OE_N,   // Output enable
   input wire logic [AW-1:0] FL_A,      // Address
   input wire logic          S_AWREADY, // AXI
   input wire logic          S_BVALID,  // AXI
   input wire logic          S_BREADY,  // AXI
   input wire logic          S_ARVALID, // AXI
   input wire logic          S_ARREADY, // AXI
   input wire logic          S_RVALID,  // AXI
   input wire logic          S_RREADY   // AXI
);
   default clocking dc @(posedge SYS_CLK);
   endclocking
   default disable iff (!RST_N);
   addr_hold_a: assert property (!FL_CE_N && !$past(FL_CE_N) |-> $stable(FL_A)) else $error("address moved");
   oe_in_ce_a: assert property (!FL_OE_N |-> !FL_CE_N) else $error("read enable outside select");
   read_end_a: assert property ($rose(FL_CE_N) |-> FL_OE_N) else $error("enable left on");
   read_bound_a: assert property ($fell(FL_CE_N) |-> ##[1:40] $rose(FL_CE_N)) else $error("read never ends");
   bvalid_hold_a: assert property (S_BVALID && !S_BREADY |=> S_BVALID) else $error("write answer dropped");
   rvalid_hold_a: assert property (S_RVALID && !S_RREADY |=> S_RVALID) else $error("read answer dropped");
   read_answer_a: assert property (S_ARVALID && S_ARREADY |=> S_RVALID) else $error("read answer late");
   awready_pulse_a: assert property (S_AWREADY |=> !S_AWREADY) else $error("address ready held");
endmodule : fwsr_host_checker
////////////////////////////////////////////////////////////
bind fwsr_host fwsr_host_checker #(.AW(AW)) u_chk (
   .SYS_CLK, .RST_N, .FL_CE_N, .FL_OE_N, .FL_A, .S_AWREADY, .S_BVALID,
   .S_BREADY, .S_ARVALID, .S_ARREADY, .S_RVALID, .S_RREADY);

// ===== bench/fwsr_flash_mdl.sv
// Behavioural flash status model: status byte and ready/busy level.
// Bench sets the operation and pulses arm together, as the final write strobe.
`timescale 1ns/1ps
module fwsr_flash_mdl (
   input wire logic        ce_n,  // Chip select
   input wire logic        oe_n,  // Output enable
   input wire logic [19:0] a,     // Address
   input wire logic [1:0]  mode,  // 0 array, 1 program (also in suspend), 2 erase, 3 suspended
   input wire logic [19:0] pa,    // Target address
   input wire logic [7:0]  pd,    // Programmed byte
   input wire logic [7:0]  nbusy, // Reads until done
   input wire logic        fail,  // Never finishes
   input wire logic        arm,   // Last command strobe
   output logic [7:0]      dq,    // Data
   output logic            rdy    // Wire level with pull-up
);
   logic [7:0] left;
   logic       t1;
   logic       t2;
   wire        rd_act = !ce_n && !oe_n;
   wire        busy   = mode inside {2'd1, 2'd2} && (fail || left != 8'h00); // Bounded unless fail, then array
   wire        qual   = (mode == 2'd1) ? (a == pa) : (mode != 2'd0);
   wire [7:0]  st     = {mode == 2'd1 ? ~pd[7] : mode == 2'd3, t1, fail, 1'b0, mode == 2'd2, t2, 2'b00};
   wire [7:0]  val    = ((busy || mode == 2'd3) && qual) ? st : (mode == 2'd2 ? 8'hff : pd);
   assign rdy = !busy;
   // No pull on data: a released bus shows the inverse
   assign dq = rd_act ? val : ~val;
   always @(posedge arm or negedge rd_act) begin
      if (arm) begin
         left <= nbusy;
         t1   <= 1'b0;
         t2   <= 1'b0;
      end else begin
         t1 <= t1 ^ busy;
         t2 <= t2 ^ (mode[1] && qual);
         if (left != 8'h00 && !fail) left <= left - 8'h01;
      end
   end
endmodule : fwsr_flash_mdl

// ===== bench/tb.sv
// Self-checking bench: AXI4-Lite master, flash status model, checker.
// Assumes the package and design are compiled first.
`timescale 1ns/1ps
module tb;
   logic        clk, rst_n, awvalid, wvalid, bready, arvalid, rready, arm, fail;
   logic        awready, wready, bvalid, arready, rvalid, ce_n, oe_n, rdy;
   logic [7:0]  awaddr, araddr, dq, pd;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp, mode;
   logic [19:0] fa, pa;
   int          errors, n_compared;
   fwsr_host i_dut (.SYS_CLK(clk), .RST_N(rst_n), .S_AWADDR(awaddr), .S_AWVALID(awvalid), .S_AWREADY(awready),
      .S_WDATA(wdata), .S_WSTRB(4'hf), .S_WVALID(wvalid), .S_WREADY(wready), .S_BRESP(bresp), .S_BVALID(bvalid),
      .S_BREADY(bready), .S_ARADDR(araddr), .S_ARVALID(arvalid), .S_ARREADY(arready), .S_RDATA(rdata),
      .S_RRESP(rresp), .S_RVALID(rvalid), .S_RREADY(rready), .FL_CE_N(ce_n), .FL_OE_N(oe_n), .FL_A(fa),
      .FL_DQ_IN(dq), .OP_DONE_PIN(rdy));
   fwsr_flash_mdl i_mdl (.ce_n(ce_n), .oe_n(oe_n), .a(fa), .mode(mode), .pa(pa), .pd(pd), .nbusy(8'h04),
      .fail(fail), .arm(arm), .dq(dq), .rdy(rdy));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         errors++;
      end
   endtask : chk
   task automatic wr(input logic [7:0] ad, input logic [31:0] d);
      logic a, w;
      @(posedge clk);
      {awaddr, wdata, awvalid, wvalid, bready} <= {ad, d, 3'b111};
      {a, w} = 2'b00;
      do begin
         @(posedge clk);
         a |= (awready === 1'b1);
         w |= (wready === 1'b1);
         {awvalid, wvalid} <= {!a, !w};
      end while (!(a && w));
      do @(posedge clk); while (bvalid !== 1'b1);
      bready <= 1'b0;
      chk("write resp", {30'h0, fwsr_pkg::AXI_OKAY}, {30'h0, bresp});
   endtask : wr
   task automatic rd(input logic [7:0] ad, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk);
      {araddr, arvalid, rready} <= {ad, 2'b11};
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      {d, r} = {rdata, rresp};
      rready <= 1'b0;
   endtask : rd
   // Sets up the model, starts a poll, waits for busy to clear
   task automatic run(input logic [1:0] m, input logic f, input logic [31:0] ctl, input logic [3:0] e, string nm);
      logic [31:0] s;
      logic [1:0]  r;
      int          k;
      {mode, fail, arm} <= {m, f, 1'b1};
      @(posedge clk);
      arm <= 1'b0;
      wr(fwsr_pkg::REG_ADDR, {12'h000, pa});
      wr(fwsr_pkg::REG_DATA, {24'h000000, pd});
      wr(fwsr_pkg::REG_CTRL, ctl);
      k = 0;
      do begin
         rd(fwsr_pkg::REG_STATUS, s, r);
         k++;
      end while (s[0] !== 1'b0 && k < 400);
      chk(nm, {28'h0, e}, s & (e[1] ? 32'hf : 32'h5));
      chk("flash address", {12'h000, pa}, {12'h000, fa});
   endtask : run
   task automatic t_poll;
      logic [31:0] s;
      logic [1:0]  r;
      run(2'd1, 1'b0, 32'h1, 4'ha, "program poll");
      rd(fwsr_pkg::REG_LAST, s, r);
      chk("program last", {24'h0, pd}, s);
      rd(fwsr_pkg::REG_STATUS, s, r);
      chk("program window", 32'h0, {31'h0, s[fwsr_pkg::ST_WINDOW]});
      run(2'd2, 1'b0, 32'h5, 4'ha, "erase poll");
      rd(fwsr_pkg::REG_LAST, s, r);
      chk("erase last", 32'hff, s);
      rd(fwsr_pkg::REG_STATUS, s, r);
      chk("erase window", 32'h1, {31'h0, s[fwsr_pkg::ST_WINDOW]});
      run(2'd3, 1'b0, 32'h5, 4'ha, "suspend poll");
   endtask : t_poll
   task automatic t_toggle;
      run(2'd1, 1'b0, 32'h3, 4'ha, "program toggle");
      run(2'd2, 1'b0, 32'h7, 4'ha, "erase toggle");
      run(2'd3, 1'b0, 32'h7, 4'ha, "suspend toggle");
   endtask : t_toggle
   task automatic t_fail;
      run(2'd1, 1'b1, 32'h1, 4'h4, "poll timeout");
      run(2'd1, 1'b1, 32'h3, 4'h4, "toggle timeout");
   endtask : t_fail
   task automatic t_unmapped;
      logic [31:0] s;
      logic [1:0]  r;
      rd(8'h20, s, r);
      chk("unmapped data", 32'h0, s);
      chk("unmapped resp", {30'h0, fwsr_pkg::AXI_SLVERR}, {30'h0, r});
   endtask : t_unmapped
   task automatic conclude;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : conclude
   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, arm, fail, mode} = '0;
      {awaddr, araddr, wdata, pa, pd} = {16'h0, 32'h0, 20'h01234, 8'h34};
      {errors, n_compared} = '0;
      repeat (6) @(posedge clk);
      rst_n <= 1'b1;
      t_poll();
      t_toggle();
      t_fail();
      t_unmapped();
      conclude();
   end
   // Each poll needs at most a few thousand cycles
   initial begin
      #2000000;
      errors++;
      conclude();
   end
endmodule : tb
